// *** its_axil_slave.sv ***
`timescale 1ns/1ps
module its_axil_slave #(
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic                   wr_en,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_ok,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_ok
);
    import its_pkg::*;
    `include "its_regs.svh"

    typedef struct packed {
        logic              aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_full;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } its_axi_t;

    its_axi_t s;
    its_axi_t next_s;

    if (ADDR_W < 5) begin : g_bad_addr
        $error("its_axil_slave: ADDR_W too small");
    end

    // Address and data are held separately so either may come first
    assign awready = !s.aw_full && !s.bvalid;
    assign wready  = !s.w_full && !s.bvalid;
    assign arready = !s.rvalid;
    assign wr_en   = s.aw_full && s.w_full && !s.bvalid;
    assign wr_addr = s.aw_addr;
    assign wr_data = s.w_data;
    assign wr_strb = s.w_strb;
    assign rd_addr = araddr;

    always_comb begin
        next_s = s;
        if (awvalid && awready) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_s.w_full = 1'b1;
            next_s.w_data = wdata;
            next_s.w_strb = wstrb;
        end
        if (wr_en) begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = wr_ok ? `ITS_RESP_OKAY : `ITS_RESP_SLVERR;
        end else if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd_data;
            next_s.rresp  = rd_ok ? `ITS_RESP_OKAY : `ITS_RESP_SLVERR;
        end else if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bvalid = s.bvalid;
    assign bresp  = s.bresp;
    assign rvalid = s.rvalid;
    assign rdata  = s.rdata;
    assign rresp  = s.rresp;
endmodule

// *** its_byte_count.sv ***
`timescale 1ns/1ps
module its_byte_count #(
    parameter int WIDTH = 11
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    input  wire logic             inc,
    output logic      [WIDTH-1:0] count,
    output logic                  at_max
);
    import its_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } its_cnt_t;

    its_cnt_t s;
    its_cnt_t next_s;

    if (WIDTH < 2) begin : g_bad_width
        $error("its_byte_count: WIDTH too small");
    end

    always_comb begin
        next_s = s;
        if (clear) begin
            next_s.count = '0;
        end else if (load) begin
            next_s.count = load_val;
        end else if (inc) begin
            // Wraps to zero past the top; callers that must abort do so
            next_s.count = s.count + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign count  = s.count;
    assign at_max = &s.count;
endmodule

// *** its_partner.sv ***
`timescale 1ns/1ps
// Remote bus party, seen through the engine's event port
module its_partner (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              go,
    input  wire its_pkg::its_evt_t sel,
    output its_pkg::its_evt_t      evt
);
    import its_pkg::*;
    // One pulse per cycle of go, so a held go gives back-to-back bytes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            evt <= '0;
        end else begin
            evt <= go ? sel : '0;
        end
    end
endmodule

// *** its_pkg.sv ***
package its_pkg;

    // Events from the protocol engine, all on mclk, pulses unless noted
    typedef struct packed {
        logic        start;
        logic [1:0]  transfer_kind;
        logic [10:0] fetch_len;
        logic        refused_target;
        logic        refused_byte;
        logic        contention_loss;
        logic        begin_fault;
        logic        end_fault;
        logic        stop_seen;
        logic        restart_seen;
        logic        byte_done;
        logic        done;
        logic        addr_match;
        logic        secondary_hit;
        logic [1:0]  frame_kind;
    } its_evt_t;

    typedef struct packed {
        logic [1:0]  rsv_hi;
        logic        second_match_flag;
        logic [8:0]  rsv_mid;
        logic [10:0] length;
        logic [1:0]  frame_kind;
        logic [2:0]  abort_cause;
        logic [1:0]  progress;
        logic [1:0]  transfer_kind;
    } its_stat_t;

endpackage

// *** its_regs.svh ***
`ifndef ITS_REGS_SVH
`define ITS_REGS_SVH

// Register byte offsets
`define ITS_ADDR_CTRL              8'h00
`define ITS_ADDR_IRQ_FLAGS         8'h04
`define ITS_ADDR_IRQ_MASK          8'h08
`define ITS_ADDR_STATUS            8'h14

// Reset values
`define ITS_CTRL_RESET             2'h0
`define ITS_IRQ_RESET              3'h0
`define ITS_STATUS_RESET           32'h0000_0000

// Control register bit positions
`define ITS_CTRL_ENABLE_BIT        0
`define ITS_CTRL_AUTO_BIT          1

// Interrupt flag bit positions
`define ITS_IRQ_DONE_BIT           0
`define ITS_IRQ_ABORT_BIT          1
`define ITS_IRQ_MATCH_BIT          2

// Transfer kind codes
`define ITS_KIND_HOST_STORE        2'h0
`define ITS_KIND_HOST_FETCH        2'h1
`define ITS_KIND_SLAVE_RECEIVE     2'h2
`define ITS_KIND_SLAVE_TRANSMIT    2'h3

// Progress codes
`define ITS_PROG_IDLE_STATE        2'h0
`define ITS_PROG_IN_PROGRESS       2'h1
`define ITS_PROG_DONE              2'h2
`define ITS_PROG_ABORTED           2'h3

// Abort reason codes
`define ITS_CAUSE_REFUSED_TARGET   3'h0
`define ITS_CAUSE_REFUSED_BYTE     3'h1
`define ITS_CAUSE_CONTENTION_LOSS  3'h3
`define ITS_CAUSE_BEGIN_FAULT      3'h4
`define ITS_CAUSE_END_FAULT        3'h5
`define ITS_CAUSE_TOO_LONG_FRAME   3'h6

// Received frame kinds
`define ITS_FRAME_NORMAL           2'h0
`define ITS_FRAME_BROADCAST_CALL   2'h1
`define ITS_FRAME_HW_BROADCAST     2'h2

// Byte count limit
`define ITS_MAX_LEN                11'h7FF

// Bus responses
`define ITS_RESP_OKAY              2'h0
`define ITS_RESP_SLVERR            2'h2

`endif

// *** its_status_core.sv ***
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Function
// - Report transfer kind in two-bit field
// - Keep two-bit progress field for all kinds
// - Host address refused: abort, reason 000
// - Host store byte refused: abort, reason 001
// - Host lost arbitration: abort, reason 011
// - Slave early STOP: bus error, reason 101
// - Slave receive frame over 2047: refuse, reason 110
// - Slave receive records received frame kind
// - Auto broadcast call: executed, count zero
// - Eleven-bit byte count per transfer kind
// - Slave transmit overrun: count wraps, no abort
// - Bit 29 shows which own address matched
// - Match flag cleared on STOP/restart/error/disable
module its_status_core #(
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire its_pkg::its_evt_t evt,
    output its_pkg::its_stat_t     status,
    output logic                   block_enable_bit,
    output logic                   slave_refuse,
    output logic                   auto_call_exec,
    output logic                   irq
);
    import its_pkg::*;
    `include "its_regs.svh"

    typedef struct packed {
        its_stat_t   stat;
        logic [1:0]  ctrl;
        logic [2:0]  irq_flags;
        logic [2:0]  irq_mask;
        logic        call_hold;
        logic        refuse;
        logic        call_exec;
        logic        irq;
    } its_core_t;

    its_core_t s;
    its_core_t next_s;

    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       rd_data;
    logic              cnt_clear;
    logic              cnt_load;
    logic              cnt_inc;
    logic [10:0]       cnt;
    logic              cnt_max;
    logic              abort;
    logic [2:0]        code;
    logic              host;
    logic [2:0]        irq_ev;
    logic [2:0]        irq_clr;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        reg_hit = (a == ADDR_W'(`ITS_ADDR_CTRL))
               || (a == ADDR_W'(`ITS_ADDR_IRQ_FLAGS))
               || (a == ADDR_W'(`ITS_ADDR_IRQ_MASK))
               || (a == ADDR_W'(`ITS_ADDR_STATUS));
    endfunction

    its_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_bus (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_ok   (reg_hit(wr_addr)),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_ok   (reg_hit(rd_addr))
    );

    its_byte_count #(
        .WIDTH (11)
    ) u_count (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .clear    (cnt_clear),
        .load     (cnt_load),
        .load_val (evt.fetch_len),
        .inc      (cnt_inc),
        .count    (cnt),
        .at_max   (cnt_max)
    );

    // Status word is read-only; reserved fields are forced to zero
    always_comb begin
        status         = s.stat;
        status.length  = cnt;
        status.rsv_hi  = '0;
        status.rsv_mid = '0;
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            ADDR_W'(`ITS_ADDR_CTRL):      rd_data[1:0] = s.ctrl;
            ADDR_W'(`ITS_ADDR_IRQ_FLAGS): rd_data[2:0] = s.irq_flags;
            ADDR_W'(`ITS_ADDR_IRQ_MASK):  rd_data[2:0] = s.irq_mask;
            ADDR_W'(`ITS_ADDR_STATUS):    rd_data = status;
            default:                      rd_data = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_s           = s;
        next_s.refuse    = 1'b0;
        next_s.call_exec = 1'b0;
        next_s.stat.length = '0;
        cnt_clear = 1'b0;
        cnt_load  = 1'b0;
        cnt_inc   = 1'b0;
        abort     = 1'b0;
        code      = `ITS_CAUSE_REFUSED_TARGET;
        irq_ev    = 3'h0;
        irq_clr   = 3'h0;
        host      = !s.stat.transfer_kind[1];

        // Status word has no write path, so writes there change nothing
        if (wr_en && wr_strb[0]) begin
            case (wr_addr)
                ADDR_W'(`ITS_ADDR_CTRL):      next_s.ctrl = wr_data[1:0];
                ADDR_W'(`ITS_ADDR_IRQ_MASK):  next_s.irq_mask = wr_data[2:0];
                ADDR_W'(`ITS_ADDR_IRQ_FLAGS): irq_clr = wr_data[2:0];
                default:                      irq_clr = 3'h0;
            endcase
        end

        if (!s.ctrl[`ITS_CTRL_ENABLE_BIT]) begin
            next_s.stat.second_match_flag = 1'b0;
        end else if (evt.start) begin
            next_s.stat.transfer_kind = evt.transfer_kind;
            next_s.stat.progress      = `ITS_PROG_IN_PROGRESS;
            next_s.stat.abort_cause   = `ITS_CAUSE_REFUSED_TARGET;
            next_s.stat.frame_kind    = `ITS_FRAME_NORMAL;
            next_s.call_hold          = 1'b0;
            // Host fetch knows its payload size up front
            cnt_load  = evt.transfer_kind == `ITS_KIND_HOST_FETCH;
            cnt_clear = !cnt_load;
        end else if (s.stat.progress == `ITS_PROG_IN_PROGRESS) begin
            // Arbitration loss outranks a refusal seen in the same cycle
            if (host && evt.contention_loss) begin
                abort = 1'b1;
                code  = `ITS_CAUSE_CONTENTION_LOSS;
            end else if (host && evt.refused_target) begin
                abort = 1'b1;
                code  = `ITS_CAUSE_REFUSED_TARGET;
            end else if (s.stat.transfer_kind == `ITS_KIND_HOST_STORE
                         && evt.refused_byte) begin
                abort = 1'b1;
                code  = `ITS_CAUSE_REFUSED_BYTE;
            end else if (!host && evt.begin_fault) begin
                abort = 1'b1;
                code  = `ITS_CAUSE_BEGIN_FAULT;
            end else if (!host && evt.end_fault) begin
                abort = 1'b1;
                code  = `ITS_CAUSE_END_FAULT;
            end else if (s.stat.transfer_kind == `ITS_KIND_SLAVE_RECEIVE
                         && evt.byte_done && cnt_max && !s.call_hold) begin
                abort         = 1'b1;
                code          = `ITS_CAUSE_TOO_LONG_FRAME;
                next_s.refuse = 1'b1;
            end else if (evt.done) begin
                next_s.stat.progress = `ITS_PROG_DONE;
                irq_ev[`ITS_IRQ_DONE_BIT] = 1'b1;
            end

            if (abort) begin
                next_s.stat.progress    = `ITS_PROG_ABORTED;
                next_s.stat.abort_cause = code;
                irq_ev[`ITS_IRQ_ABORT_BIT] = 1'b1;
            end

            // Slave transmit simply wraps past the top of the count
            cnt_inc = evt.byte_done && !abort && !s.call_hold
                   && s.stat.transfer_kind != `ITS_KIND_HOST_FETCH;

            if (!host && evt.addr_match) begin
                next_s.stat.second_match_flag = evt.secondary_hit;
                irq_ev[`ITS_IRQ_MATCH_BIT] = 1'b1;
                if (s.stat.transfer_kind == `ITS_KIND_SLAVE_RECEIVE) begin
                    next_s.stat.frame_kind = evt.frame_kind;
                    if (evt.frame_kind == `ITS_FRAME_BROADCAST_CALL
                        && s.ctrl[`ITS_CTRL_AUTO_BIT]) begin
                        // Only the control word goes to the engine's FIFO
                        next_s.call_exec = 1'b1;
                        next_s.call_hold = 1'b1;
                        cnt_clear        = 1'b1;
                        cnt_inc          = 1'b0;
                    end
                end
            end
        end

        if (evt.stop_seen || evt.restart_seen
            || (abort && !host)) begin
            next_s.stat.second_match_flag = 1'b0;
        end

        // A new event wins over a clear in the same cycle
        next_s.irq_flags = (s.irq_flags & ~irq_clr) | irq_ev;
        next_s.irq = |(next_s.irq_flags & next_s.irq_mask);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign block_enable_bit = s.ctrl[`ITS_CTRL_ENABLE_BIT];
    assign slave_refuse     = s.refuse;
    assign auto_call_exec   = s.call_exec;
    assign irq              = s.irq;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    logic run_q;
    assign run_q = s.ctrl[`ITS_CTRL_ENABLE_BIT]
                && s.stat.progress == `ITS_PROG_IN_PROGRESS && !evt.start;

    kind_load_a: assert property (
        (block_enable_bit && evt.start) |=>
        status.transfer_kind == $past(evt.transfer_kind))
        else $error("transfer kind not loaded at start");

    prog_run_a: assert property (
        (block_enable_bit && evt.start) |=>
        status.progress == `ITS_PROG_IN_PROGRESS)
        else $error("progress not in_progress after start");

    host_refuse_a: assert property (
        (run_q && host && evt.refused_target && !evt.contention_loss) |=>
        status.progress == `ITS_PROG_ABORTED
        && status.abort_cause == `ITS_CAUSE_REFUSED_TARGET)
        else $error("address refusal not recorded");

    byte_refuse_a: assert property (
        (run_q && evt.refused_byte && !evt.refused_target
         && !evt.contention_loss
         && s.stat.transfer_kind == `ITS_KIND_HOST_STORE) |=>
        status.abort_cause == `ITS_CAUSE_REFUSED_BYTE)
        else $error("data refusal not recorded");

    arb_loss_a: assert property (
        (run_q && host && evt.contention_loss) |=>
        status.abort_cause == `ITS_CAUSE_CONTENTION_LOSS
        && status.progress == `ITS_PROG_ABORTED)
        else $error("arbitration loss not recorded");

    begin_fault_a: assert property (
        (run_q && !host && evt.begin_fault) |=>
        status.abort_cause == `ITS_CAUSE_BEGIN_FAULT
        && !status.second_match_flag)
        else $error("early start not recorded");

    end_fault_a: assert property (
        (run_q && !host && !evt.begin_fault && evt.end_fault) |=>
        status.abort_cause == `ITS_CAUSE_END_FAULT)
        else $error("early stop not recorded");

    overflow_a: assert property (
        slave_refuse |-> status.abort_cause == `ITS_CAUSE_TOO_LONG_FRAME
        && status.progress == `ITS_PROG_ABORTED
        && status.transfer_kind == `ITS_KIND_SLAVE_RECEIVE)
        else $error("refusal without overflow abort");

    tx_wrap_a: assert property (
        (run_q && s.stat.transfer_kind == `ITS_KIND_SLAVE_TRANSMIT
         && evt.byte_done && !evt.done && cnt_max && !evt.begin_fault
         && !evt.end_fault && !evt.addr_match && !s.call_hold) |=>
        status.length == 11'h000
        && status.progress == `ITS_PROG_IN_PROGRESS)
        else $error("slave transmit overrun mishandled");

    auto_call_a: assert property (
        auto_call_exec |-> status.length == 11'h000
        && status.frame_kind == `ITS_FRAME_BROADCAST_CALL)
        else $error("auto call count not zero");

    match_clear_a: assert property (
        (evt.stop_seen || !block_enable_bit) |=>
        !status.second_match_flag)
        else $error("match flag not cleared");

    rsv_zero_a: assert property (
        status.rsv_hi == 2'h0 && status.rsv_mid == 9'h000)
        else $error("reserved status bits set");

    irq_level_a: assert property (
        irq == |(s.irq_flags & s.irq_mask))
        else $error("interrupt output disagrees with flags");

    done_c: cover property (
        status.progress == `ITS_PROG_IN_PROGRESS
        ##[1:20] status.progress == `ITS_PROG_DONE);
    overflow_c: cover property (slave_refuse);
    second_c: cover property (status.second_match_flag);
    auto_call_c: cover property (auto_call_exec);
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import its_pkg::*;
    logic        mclk = 0;
    logic        rst_n = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, go = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        ben, refuse, autox, irq;
    its_evt_t    sel = '0, evt, e;
    its_stat_t   status;
    int          error_cnt = 0, total_checks = 0, n_ref = 0, n_auto = 0;
    int          kd[8] = '{0, 0, 1, 2, 3, 1, 1, 2};
    logic [31:0] ex[8] = '{32'h0C, 32'h1C, 32'hA3D, 32'h4E, 32'h5F,
                           32'hA09, 32'hA05, 32'h06};

    its_status_core u_its_status_core (.mclk(mclk), .rst_n(rst_n),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .evt(evt),
        .status(status), .block_enable_bit(ben), .slave_refuse(refuse),
        .auto_call_exec(autox), .irq(irq));
    its_partner u_its_partner (.mclk(mclk), .rst_n(rst_n), .go(go),
        .sel(sel), .evt(evt));

    initial begin
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        n_ref += (refuse === 1'b1);
        n_auto += (autox === 1'b1);
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    // Unmapped places answer with an error response
    function automatic logic [1:0] rsp(logic [7:0] a);
        return (a inside {8'h00, 8'h04, 8'h08, 8'h14}) ? 2'h0 : 2'h2;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        logic [1:0] r;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            #1 ta = awready;
            tw = wready;
            tb = bvalid;
            r = bresp;
            @(posedge mclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
        end while (!tb);
        // Ready stays up between calls so no step drives it twice
        chk(r, rsp(a));
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        logic ta, tv;
        logic [31:0] d;
        logic [1:0] r;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            #1 ta = arready;
            tv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge mclk);
            if (ta) arvalid <= 0;
        end while (!tv);
        chk(d, x);
        chk(r, rsp(a));
    endtask
    task automatic evn(input its_evt_t v, input int n);
        sel <= v;
        go <= 1;
        repeat (n) @(posedge mclk);
        go <= 0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic st(input logic [1:0] k);
        e = '0;
        e.start = 1;
        e.transfer_kind = k;
        e.fetch_len = 11'h005;
        evn(e, 1);
        e = '0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        give_verdict;
    end

    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        chk(status, 32'h0);
        wr(8'h14, 32'hFFFF_FFFF);
        rc(8'h14, 32'h0);
        wr(8'h0C, 32'h1);
        rc(8'h10, 32'h0);
        wr(8'h00, 32'h1);
        wr(8'h08, 32'h7);
        for (int i = 0; i < 8; i++) begin
            st(kd[i][1:0]);
            case (i)
                0, 7: e.refused_target = 1;
                1, 6: e.refused_byte = 1;
                2: e.contention_loss = 1;
                3: e.begin_fault = 1;
                4: e.end_fault = 1;
                default: e.done = 1;
            endcase
            evn(e, 1);
            rc(8'h14, ex[i]);
        end
        $display("test table done");
        st(2);
        e.addr_match = 1;
        e.secondary_hit = 1;
        e.frame_kind = 2'h1;
        evn(e, 1);
        e = '0;
        e.byte_done = 1;
        evn(e, 3);
        rc(8'h14, 32'h2000_0686);
        e = '0;
        e.stop_seen = 1;
        e.done = 1;
        evn(e, 1);
        rc(8'h14, 32'h0000_068A);
        st(2);
        e.byte_done = 1;
        evn(e, 2047);
        rc(8'h14, 32'h000F_FE06);
        evn(e, 1);
        rc(8'h14, 32'h000F_FE6E);
        chk(n_ref, 1);
        st(3);
        e.byte_done = 1;
        evn(e, 2048);
        rc(8'h14, 32'h7);
        $display("test counts done");
        // Automatic broadcast handling keeps the count at zero
        wr(8'h00, 32'h3);
        st(2);
        e.addr_match = 1;
        e.frame_kind = 2'h1;
        evn(e, 1);
        e = '0;
        e.byte_done = 1;
        evn(e, 2);
        rc(8'h14, 32'h86);
        chk(n_auto, 1);
        wr(8'h00, 32'h1);
        st(2);
        e.addr_match = 1;
        e.secondary_hit = 1;
        evn(e, 1);
        rc(8'h14, 32'h2000_0006);
        e = '0;
        e.restart_seen = 1;
        evn(e, 1);
        rc(8'h14, 32'h6);
        e = '0;
        e.addr_match = 1;
        e.secondary_hit = 1;
        evn(e, 1);
        rc(8'h14, 32'h2000_0006);
        wr(8'h00, 32'h0);
        chk(ben, 1'b0);
        rc(8'h14, 32'h6);
        chk(irq, 1'b1);
        wr(8'h08, 32'h0);
        chk(irq, 1'b0);
        wr(8'h04, 32'h7);
        rc(8'h04, 32'h0);
        wr(8'h08, 32'h7);
        chk(irq, 1'b0);
        $display("test slave and irq done");
        rst_n <= 0;
        repeat (2) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        rc(8'h14, 32'h0);
        rc(8'h00, 32'h0);
        $display("test reset done");
        give_verdict;
    end
endmodule
